// File: verilog/step_dir_input_gearing.v
/*
 Step/direction input with signed fixed-point electronic gearing: direct mode
 emits internal steps, indirect mode nudges the target position, and the handover
 from external to internal ramp control.
 Assumes an outside ramp generator that consumes the handover outputs, and an
 external step source on pins asynchronous to clock.
*/
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/100ps
`include "gearing_map.vh"
module step_dir_input_gearing #(
   parameter DATA_WIDTH = 32,
   parameter ACC_FRAC = 24
) (
   // Clock and reset
   input wire clock,
   input wire sys_rst,
   // Register port
   input wire [7:0] reg_addr,
   input wire [31:0] reg_wdata,
   input wire reg_write,
   input wire reg_read,
   output reg [31:0] reg_rdata,
   // External step interface
   input wire step_pulse_input,
   input wire direction_input,
   // Step output
   output reg step_pulse_output,
   output reg step_direction,
   // Internal generator control
   output wire internal_gen_enable,
   output reg handover_start,
   output reg [31:0] handover_velocity,
   output reg signed [31:0] handover_acceleration,
   output reg handover_direction,
   output reg [31:0] handover_step_age
);
   reg [31:0] general_config_word;
   reg signed [31:0] gearing_factor;
   reg [31:0] start_velocity;
   reg [31:0] start_acceleration;
   reg signed [31:0] target_position;
   reg signed [31:0] actual_position;
   reg [ACC_FRAC-1:0] accumulator;
   reg [7:0] pending_steps;
   reg pending_dir;
   reg [7:0] burst_timer;
   reg step_prev;
   reg last_ext_dir;
   reg [31:0] step_age;
   reg [1:0] edge_sel_prev;
   wire step_sync_level;
   wire dir_sync_level;
   wire [1:0] edge_sel;
   wire dir_pol;
   wire indirect_mode;
   wire rise;
   wire fall;
   reg ext_step;
   wire pin_negative;
   wire move_negative;
   wire [31:0] gear_mag;
   wire [ACC_FRAC:0] acc_sum;
   wire [7:0] int_part;
   wire [7:0] overflow_count;
   wire step_emit;

   step_sync u_step_sync (
      .clock(clock),
      .sys_rst(sys_rst),
      .pin(step_pulse_input),
      .level(step_sync_level)
   );

   step_sync u_dir_sync (
      .clock(clock),
      .sys_rst(sys_rst),
      .pin(direction_input),
      .level(dir_sync_level)
   );

   assign edge_sel = general_config_word[`CFG_EDGE_HI:`CFG_EDGE_LO];
   assign dir_pol = general_config_word[`CFG_DIR_POL];
   assign indirect_mode = (edge_sel != `EDGE_OFF) && general_config_word[`CFG_INDIRECT];
   assign internal_gen_enable = (edge_sel == `EDGE_OFF);

   // Edge detection reads only the second synchroniser stage
   assign rise = step_sync_level && !step_prev;
   assign fall = !step_sync_level && step_prev;

   always @* begin
      case (edge_sel)
         `EDGE_RISE: ext_step = rise;
         `EDGE_FALL: ext_step = fall;
         `EDGE_BOTH: ext_step = rise || fall;
         default: ext_step = 1'b0;
      endcase
   end

   // Negative when pin equals polarity bit
   assign pin_negative = (dir_sync_level == dir_pol);
   assign move_negative = pin_negative ^ gearing_factor[31];

   // Magnitude of signed 8.24 factor
   assign gear_mag = gearing_factor[31] ? (~gearing_factor + 32'h0000_0001) : gearing_factor;
   assign acc_sum = {1'b0, accumulator} + {1'b0, gear_mag[ACC_FRAC-1:0]};
   assign int_part = gear_mag[31:ACC_FRAC];
   // Integer part up to 128, or 127 plus one carry, fits in eight bits
   assign overflow_count = int_part + {7'h00, acc_sum[ACC_FRAC]};
   assign step_emit = (pending_steps != 8'h00) && (burst_timer == 8'h00);

   always @(posedge clock) begin
      if (sys_rst) begin
         step_prev <= 1'b0;
         accumulator <= {ACC_FRAC{1'b0}};
         pending_steps <= 8'h00;
         pending_dir <= 1'b0;
         burst_timer <= 8'h00;
         step_pulse_output <= 1'b0;
         step_direction <= 1'b0;
         target_position <= 32'sh0000_0000;
         actual_position <= 32'sh0000_0000;
         last_ext_dir <= 1'b0;
         step_age <= 32'h0000_0000;
      end else begin
         step_prev <= step_sync_level;
         step_pulse_output <= 1'b0;
         if (burst_timer != 8'h00) begin
            burst_timer <= burst_timer - 8'h01;
         end
         if (step_age != 32'hFFFF_FFFF) begin
            step_age <= step_age + 32'h0000_0001;
         end
         // Spacing of 64 cycles lets a 127-step burst at one step per 3 cycles drain in time only for
         // smaller factors; a new step adds to what is still pending
         if (ext_step) begin
            accumulator <= acc_sum[ACC_FRAC-1:0];
            last_ext_dir <= move_negative;
            if (indirect_mode) begin
               if (overflow_count != 8'h00) begin
                  if (move_negative) begin
                     target_position <= target_position - {{24{1'b0}}, overflow_count};
                  end else begin
                     target_position <= target_position + {{24{1'b0}}, overflow_count};
                  end
               end
            end else begin
               pending_steps <= pending_steps - {7'h00, step_emit} + overflow_count;
               pending_dir <= move_negative;
            end
         end else if (step_emit) begin
            pending_steps <= pending_steps - 8'h01;
         end
         if (step_emit) begin
            step_pulse_output <= 1'b1;
            step_direction <= pending_dir;
            burst_timer <= `BURST_STEP_PERIOD;
            step_age <= 32'h0000_0000;
            if (pending_dir) begin
               actual_position <= actual_position - 32'sh0000_0001;
            end else begin
               actual_position <= actual_position + 32'sh0000_0001;
            end
         end
      end
   end

   // Handover when edge select returns to zero from direct mode
   always @(posedge clock) begin
      if (sys_rst) begin
         edge_sel_prev <= `EDGE_OFF;
         handover_start <= 1'b0;
         handover_velocity <= 32'h0000_0000;
         handover_acceleration <= 32'sh0000_0000;
         handover_direction <= 1'b0;
         handover_step_age <= 32'h0000_0000;
      end else begin
         edge_sel_prev <= edge_sel;
         handover_start <= 1'b0;
         if ((edge_sel_prev != `EDGE_OFF) && (edge_sel == `EDGE_OFF) && general_config_word[`CFG_AUTO_HANDOVER]
             && !general_config_word[`CFG_INDIRECT]) begin
            handover_start <= 1'b1;
            handover_velocity <= start_velocity;
            handover_direction <= last_ext_dir;
            handover_step_age <= step_age;
            if (start_acceleration[31]) begin
               handover_acceleration <= -$signed({1'b0, start_acceleration[30:0]});
            end else begin
               handover_acceleration <= $signed({1'b0, start_acceleration[30:0]});
            end
         end
      end
   end

   // Register writes; target is moved only by gearing, host writes to it are ignored
   always @(posedge clock) begin
      if (sys_rst) begin
         general_config_word <= `RST_CONFIG;
         gearing_factor <= `RST_GEARING;
         start_velocity <= 32'h0000_0000;
         start_acceleration <= 32'h0000_0000;
      end else if (reg_write) begin
         case (reg_addr)
            `REG_GENERAL_CONFIG_WORD: general_config_word <= reg_wdata;
            `REG_GEARING_FACTOR: gearing_factor <= reg_wdata;
            `REG_START_VELOCITY: start_velocity <= reg_wdata;
            `REG_START_ACCELERATION: start_acceleration <= reg_wdata;
            default: ;
         endcase
      end
   end

   // Read data one cycle after the strobe; unmapped reads zero
   always @(posedge clock) begin
      if (sys_rst) begin
         reg_rdata <= 32'h0000_0000;
      end else if (reg_read) begin
         case (reg_addr)
            `REG_GENERAL_CONFIG_WORD: reg_rdata <= general_config_word;
            `REG_GEARING_FACTOR: reg_rdata <= gearing_factor;
            `REG_START_VELOCITY: reg_rdata <= start_velocity;
            `REG_START_ACCELERATION: reg_rdata <= start_acceleration;
            `REG_TARGET_POSITION: reg_rdata <= target_position;
            `REG_ACTUAL_POSITION: reg_rdata <= actual_position;
            `REG_HANDOVER_STATUS: reg_rdata <= {22'h00_0000, last_ext_dir, indirect_mode, pending_steps};
            default: reg_rdata <= 32'h0000_0000;
         endcase
      end else begin
         reg_rdata <= 32'h0000_0000;
      end
   end
endmodule // step_dir_input_gearing

// File: verilog/gearing_map.vh
/*
 Offsets, field positions, reset values and timing counts for the step/direction
 input gearing block. Assumes inclusion by bare name from the design files.
*/
`ifndef GEARING_MAP_VH
`define GEARING_MAP_VH
// Register indices (printed offsets); byte address is four times the index
`define REG_GENERAL_CONFIG_WORD 8'h00
`define REG_GEARING_FACTOR 8'h12
`define REG_START_VELOCITY 8'h25
`define REG_START_ACCELERATION 8'h2A
`define REG_TARGET_POSITION 8'h37
`define REG_ACTUAL_POSITION 8'h21
`define REG_HANDOVER_STATUS 8'h38
// Config field positions
`define CFG_EDGE_LO 6
`define CFG_EDGE_HI 7
`define CFG_DIR_POL 8
`define CFG_INDIRECT 9
`define CFG_AUTO_HANDOVER 26
// Edge select codes
`define EDGE_OFF 2'b00
`define EDGE_RISE 2'b01
`define EDGE_FALL 2'b10
`define EDGE_BOTH 2'b11
// Reset values
`define RST_CONFIG 32'h0000_0000
`define RST_GEARING 32'h0100_0000
// Timing
`define MIN_STEP_SPACING_CYCLES 64
`define BURST_STEP_PERIOD 8'h02
`endif

// File: verilog/step_sync.v
/*
 Two-stage synchroniser for one asynchronous pin.
 Assumes one system clock and a synchronous active high reset.
*/
`timescale 1ns/100ps
module step_sync (
   // Clock and reset
   input wire clock,
   input wire sys_rst,
   // Pin and result
   input wire pin,
   output reg level
);
   reg stage1;

   always @(posedge clock) begin
      if (sys_rst) begin
         stage1 <= 1'b0;
         level <= 1'b0;
      end else begin
         stage1 <= pin;
         level <= stage1;
      end
   end
endmodule // step_sync

// File: tb/gearing_chk.sv
/* Port checker for the gearing block.
 Assumes a bind onto step_dir_input_gearing. */
`timescale 1ns/100ps
module gearing_chk (
   // Clock, reset, register port
   input wire clock,
   input wire sys_rst,
   input wire [7:0] reg_addr,
   input wire [31:0] reg_wdata,
   input wire reg_write,
   input wire reg_read,
   input wire [31:0] reg_rdata,
   // Step and handover pins
   input wire step_pulse_input,
   input wire direction_input,
   input wire step_pulse_output,
   input wire step_direction,
   input wire internal_gen_enable,
   input wire handover_start,
   input wire [31:0] handover_velocity,
   input wire signed [31:0] handover_acceleration
);
   reg [31:0] cfg, gear, sv, sa;
   always @(posedge clock) begin
      if (sys_rst) begin
         cfg <= 32'h0000_0000;
         gear <= 32'h0100_0000;
      end else if (reg_write) begin
         if (reg_addr == 8'h00) cfg <= reg_wdata;
         if (reg_addr == 8'h12) gear <= reg_wdata;
         if (reg_addr == 8'h25) sv <= reg_wdata;
         if (reg_addr == 8'h2A) sa <= reg_wdata;
      end
   end
   // Unit ratio only, so every edge is exactly one step
   wire unit = gear == 32'h0100_0000 && !cfg[9];
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   gen_cfg_a: assert property (internal_gen_enable == (cfg[7:6] == 2'b00))
      else $error("gen enable wrong");
   rise_step_a: assert property ($rose(step_pulse_input) && cfg[7:6] == 2'b01 && unit |-> ##[2:5] step_pulse_output)
      else $error("rise step missing");
   fall_step_a: assert property ($fell(step_pulse_input) && cfg[7:6] == 2'b10 && unit |-> ##[2:5] step_pulse_output)
      else $error("fall step missing");
   both_step_a: assert property ($changed(step_pulse_input) && cfg[7:6] == 2'b11 && unit |-> ##[2:5] step_pulse_output)
      else $error("edge step missing");
   step_dir_a: assert property (step_pulse_output |-> step_direction == ((direction_input == cfg[8]) ^ gear[31]))
      else $error("step direction wrong");
   burst_gap_a: assert property (step_pulse_output |=> !step_pulse_output ##1 !step_pulse_output)
      else $error("burst spacing wrong");
   ind_quiet_a: assert property (cfg[9] && cfg[7:6] != 2'b00 |-> !step_pulse_output)
      else $error("pulse in indirect mode");
   ho_data_a: assert property (handover_start |-> handover_velocity == sv &&
      handover_acceleration == (sa[31] ? -{1'b0, sa[30:0]} : {1'b0, sa[30:0]})) else $error("handover data wrong");
   gear_read_a: assert property ($past(reg_read) && $past(reg_addr) == 8'h12 |-> reg_rdata == gear)
      else $error("gearing readback wrong");
endmodule // gearing_chk
bind step_dir_input_gearing gearing_chk u_chk (.clock, .sys_rst, .reg_addr, .reg_wdata, .reg_write, .reg_read,
   .reg_rdata, .step_pulse_input, .direction_input, .step_pulse_output, .step_direction, .internal_gen_enable,
   .handover_start, .handover_velocity, .handover_acceleration);

// File: tb/ext_step_source.sv
/* Outside step source: one pulse of opposite level per request.
 Assumes go is raised only while busy is low. */
`timescale 1ns/100ps
module ext_step_source (
   // Clock and request
   input wire clock,
   input wire go,
   input wire dir_level,
   input wire idle_level,
   // Pins
   output reg step_pin = 1'b0,
   output reg dir_pin = 1'b0,
   output wire busy
);
   reg [7:0] cnt = 8'h00;
   assign busy = cnt != 8'h00;
   always @(posedge clock) begin
      if (go && !busy) begin
         cnt <= 8'h01;
         dir_pin <= dir_level;
      end else if (busy) begin
         // Edges 70 cycles apart, so both-edge mode stays legal
         cnt <= (cnt == 8'h90) ? 8'h00 : cnt + 8'h01;
      end
      if (cnt == 8'h06) step_pin <= ~idle_level;
      else if (cnt == 8'h4C || !busy) step_pin <= idle_level;
   end
endmodule // ext_step_source

// File: tb/testbench.sv
/* Self-checking bench for the gearing block.
 Assumes the step source model and the bound port checker. */
`timescale 1ns/100ps
module testbench;
   reg clock = 1'b0;
   reg sys_rst = 1'b1;
   reg [7:0] reg_addr = 8'h00;
   reg [31:0] reg_wdata = 32'h0000_0000;
   reg reg_write = 1'b0;
   reg reg_read = 1'b0;
   reg go = 1'b0;
   reg dir_level = 1'b0;
   reg idle_level = 1'b0;
   wire [31:0] reg_rdata, handover_velocity, handover_step_age;
   wire signed [31:0] handover_acceleration;
   wire step_pin, dir_pin, busy, step_pulse_output, step_direction, internal_gen_enable, handover_start;
   wire handover_direction;
   integer err_count = 0, tests_run = 0, i, j, e, n, p;
   reg [31:0] g, acc, k, tgt, v, sv, sa, cfg;
   reg ndir;
   always #50 clock = ~clock;
   ext_step_source u_src (.clock, .go, .dir_level, .idle_level, .step_pin, .dir_pin, .busy);
   step_dir_input_gearing u_dut (.clock, .sys_rst, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
      .step_pulse_input(step_pin), .direction_input(dir_pin), .step_pulse_output, .step_direction,
      .internal_gen_enable, .handover_start, .handover_velocity, .handover_acceleration, .handover_direction,
      .handover_step_age);
   function [31:0] accum(input [31:0] a, input [31:0] gr);
      accum = a + (gr[31] ? -gr : gr);
   endfunction
   task check(input [31:0] seen, input [31:0] exp);
      begin
         tests_run = tests_run + 1;
         if (seen !== exp) begin
            err_count = err_count + 1;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   task summarize;
      begin
         $display("Checks %0d mismatches %0d", tests_run, err_count);
         if (err_count == 0 && tests_run > 0) $display("All tests passed");
         else $display("Some tests failed");
         $finish;
      end
   endtask
   task wr(input [7:0] a, input [31:0] d);
      begin
         reg_addr <= a;
         reg_wdata <= d;
         reg_write <= 1'b1;
         @(posedge clock);
         reg_write <= 1'b0;
         @(posedge clock);
      end
   endtask
   task rd(input [7:0] a, output [31:0] d);
      begin
         reg_addr <= a;
         reg_read <= 1'b1;
         @(posedge clock);
         reg_read <= 1'b0;
         #1 d = reg_rdata;
         @(posedge clock);
      end
   endtask
   task setcfg(input [31:0] c);
      begin
         cfg = c;
         wr(8'h00, c);
      end
   endtask
   task idle(input l);
      begin
         idle_level <= l;
         repeat (8) @(posedge clock);
      end
   endtask
   task rst;
      begin
         sys_rst <= 1'b1;
         repeat (16) @(posedge clock);
         sys_rst <= 1'b0;
         cfg = 32'h0000_0000;
         g = 32'h0100_0000;
         acc = 32'h0000_0000;
         tgt = 32'h0000_0000;
         @(posedge clock);
      end
   endtask
   // One request, then count output pulses over the whole burst
   task stp(input d);
      begin
         dir_level <= d;
         go <= 1'b1;
         @(posedge clock);
         go <= 1'b0;
         n = 0;
         p = 0;
         for (i = 0; i < 600; i = i + 1) begin
            @(posedge clock);
            #1;
            if (step_pulse_output === 1'b1) begin
               n = n + 1;
               p = i;
            end
         end
         k = 0;
         for (j = 0; j < ((cfg[7:6] == 2'b11) ? 2 : 1); j = j + 1) begin
            acc = accum(acc, g);
            k = k + acc[31:24];
            acc = {8'h00, acc[23:0]};
         end
         ndir = (d == cfg[8]) ^ g[31];
         if (cfg[9]) tgt = ndir ? tgt - k : tgt + k;
         check(n, cfg[9] ? 0 : k);
         if (k != 0 && !cfg[9]) check(step_direction, ndir);
      end
   endtask
   initial begin
      i = $urandom(3049);
      rst;
      setcfg(32'h0000_0040);
      stp(1);
      stp(0);
      idle(1);
      setcfg(32'h0000_0080);
      stp(1);
      idle(0);
      setcfg(32'h0000_01C0);
      stp(1);
      $display("Edge modes done");
      setcfg(32'h0000_0040);
      for (e = 0; e < 14; e = e + 1) begin
         g = (e == 0) ? 32'h0000_0001 : (e == 1) ? 32'h7F00_0000 : $urandom % 32'h0400_0000 + 1;
         wr(8'h12, g);
         rd(8'h12, v);
         check(v, g);
         stp($urandom % 2);
      end
      $display("Gearing done");
      rst;
      g = 32'hFF00_0000;
      wr(8'h12, g);
      setcfg(32'h0000_0040);
      stp(1);
      $display("Negative gearing done");
      rst;
      setcfg(32'h0000_0240);
      g = 32'h0200_0000;
      wr(8'h12, g);
      stp(1);
      stp(1);
      stp(0);
      wr(8'h37, 32'h1234_5678);
      rd(8'h37, v);
      check(v, tgt);
      rd(8'h21, v);
      check(v, 32'h0000_0000);
      rd(8'h7F, v);
      check(v, 32'h0000_0000);
      $display("Indirect mode done");
      rst;
      sv = $urandom;
      sa = $urandom | 32'h8000_0000;
      wr(8'h25, sv);
      wr(8'h2A, sa);
      setcfg(32'h0400_0040);
      stp(0);
      setcfg(32'h0400_0000);
      #1;
      for (i = 0; i < 10 && handover_start !== 1'b1; i = i + 1) begin
         @(posedge clock);
         #1;
      end
      if (i == 10) begin
         err_count = err_count + 1;
         summarize;
      end
      check(handover_velocity, sv);
      check(handover_acceleration, -{1'b0, sa[30:0]});
      check(handover_direction, 1'b1);
      // Age counts the edges from the last pulse up to the config write edge
      check(handover_step_age, 600 - p);
      check(internal_gen_enable, 1'b1);
      $display("Handover done");
      summarize;
   end
endmodule // testbench
